// ==== core/dio_pkg.sv ====
// Shared constants and carrier types for the digital I/O port bank
package dio_pkg;
  localparam logic [9:0]  ADDR_CTRL_LOW     = 10'h321;
  localparam logic [9:0]  ADDR_INTERNAL     = 10'h322;
  localparam logic [9:0]  ADDR_STATUS_A     = 10'h323;
  localparam logic [9:0]  ADDR_STATUS_B     = 10'h324;
  localparam logic [9:0]  ADDR_CTRL_HIGH    = 10'h325;
  localparam logic [7:0]  RESET_OUTPUTS     = 8'hff;
  localparam logic [15:0] RESET_RELAY       = 16'hffff;
  localparam logic [1:0]  INPUT_PAD         = 2'h3;
  localparam logic [3:0]  CTRL_HIGH_PAD     = 4'hf;
  localparam int          BIT_HEALTH        = 0;
  localparam int          BIT_SEQUENCE      = 2;
  localparam int          BIT_DIAG          = 3;
  localparam int          BIT_THERMAL       = 4;
  localparam int          BIT_PRESSURE      = 5;
  localparam int          BIT_KEEPALIVE     = 0;
  localparam int          BIT_PUMP          = 1;
  localparam int          WATCHDOG_SECONDS  = 5;
  localparam longint      CLOCK_HZ          = 125000000;
  localparam longint      WATCHDOG_CYCLES   = WATCHDOG_SECONDS * CLOCK_HZ;
  localparam int          SYNC_STAGES       = 3;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [9:0] addr;
    logic [7:0] wdata;
  } io_req_s;

  typedef struct packed {
    logic       health_flag_n;
    logic       sequence_running_n;
    logic       diagnostics_active_n;
    logic       thermal_alarm_n;
    logic       pressure_fault_n;
  } status_s;
endpackage

// ==== core/dio_input_sync.sv ====
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ns
module dio_input_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_pins,
  output logic      [WIDTH-1:0] o_levels
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta;
      logic s2;
      logic s3;
      logic level;
      always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
          meta <= 1'b1;
          s2 <= 1'b1;
          s3 <= 1'b1;
        end else begin
          meta <= i_pins[g];
          s2 <= meta;
          s3 <= s2;
        end
      end
      // Idle pins read de-asserted (high) after reset
      always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
          level <= 1'b1;
        end else if (s2 == s3) begin
          level <= s3;
        end
      end
      assign o_levels[g] = level;
    end
  endgenerate
endmodule

// ==== core/dio_ports.sv ====
// Byte-wide digital I/O port bank with status flags and relay board port
//
// Behaviour
// R1: Port 0x321 read returns remote inputs 1-6 active low, bits 6-7 one.
// R2: Port 0x325 read returns remote inputs 7-12 active low, bits 6-7 one.
// R3: Write to 0x321 drives control outputs 1-8, zero asserts.
// R4: Write to 0x325 bits 0-3 drives control outputs 9-12, active low.
// R5: Port 0x322 read returns eight spare internal input bits.
// R6: Status bit 0 is zero when healthy, one on alarm or diagnostics.
// R7: Status bit 2 is zero while a calibration sequence runs.
// R8: Status bit 3 is zero while in diagnostic mode.
// R9: Status bit 4 is zero on any temperature alarm.
// R10: Status bit 5 is zero on any pressure alarm; bits 1,6,7 spare.
// R11: Write to 0x324 drives eight spare status outputs.
// R12: Firmware toggles relay keep-alive bit at least every five seconds.
// R13: Relay bit 1 zero turns zero-air pump on; bits 2-5 spare.
// R14: Keep-alive stale beyond five seconds forces relay outputs inactive.
// R15: Outputs hold last write; input reads return synchronised samples.
`timescale 1ns/1ns
module dio_ports #(
  parameter longint WATCHDOG_LIMIT = dio_pkg::WATCHDOG_CYCLES
) (
  input  wire logic            i_sys_clk,
  input  wire logic            i_rst,
  input  wire dio_pkg::io_req_s i_io_req,
  output logic [7:0]           o_io_rdata,
  output logic                 o_io_ack,
  input  wire logic [11:0]     i_remote_in_n,
  input  wire logic [7:0]      i_internal_in,
  output logic [11:0]          o_control_out_n,
  output logic [7:0]           o_internal_out,
  output logic [7:0]           o_status_a,
  output logic [7:0]           o_status_b,
  input  wire logic            i_relay_wr,
  input  wire logic [15:0]     i_relay_wdata,
  output logic [15:0]          o_relay_out,
  output dio_pkg::status_s     o_status_flags,
  output logic                 o_relay_active
);
  import dio_pkg::*;

  // Relay board port: safe until the keep-alive bit proves firmware is alive
  typedef enum logic {
    RELAY_SAFE,
    RELAY_LIVE
  } relay_state_e;

  logic [11:0] remote_sync;
  logic [7:0]  internal_sync;
  logic [7:0]  ctrl_low;
  logic [3:0]  ctrl_high;
  logic [7:0]  internal_out;
  logic [7:0]  status_a;
  logic [7:0]  status_b;
  logic [15:0] relay_reg;
  logic        keepalive_last;
  logic [39:0] stale_count;
  logic        relay_active;
  logic [7:0]  next_rdata;
  logic        wr_low;
  logic        wr_high;
  logic        wr_int;
  logic        wr_sta;
  logic        wr_stb;
  logic        any_req;
  logic        keepalive_toggled;
  logic        window_expired;
  logic [7:0]  remote_low_byte;
  logic [7:0]  remote_high_byte;
  logic [15:0] relay_masked;
  relay_state_e relay_state;

  dio_input_sync #(
    .WIDTH(12)
  ) u_remote_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_pins    (i_remote_in_n),
    .o_levels  (remote_sync)
  );

  dio_input_sync #(
    .WIDTH(8)
  ) u_internal_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_pins    (i_internal_in),
    .o_levels  (internal_sync)
  );

  assign wr_low  = i_io_req.wr && (i_io_req.addr == ADDR_CTRL_LOW);
  assign wr_high = i_io_req.wr && (i_io_req.addr == ADDR_CTRL_HIGH);
  assign wr_int  = i_io_req.wr && (i_io_req.addr == ADDR_INTERNAL);
  assign wr_sta  = i_io_req.wr && (i_io_req.addr == ADDR_STATUS_A);
  assign wr_stb  = i_io_req.wr && (i_io_req.addr == ADDR_STATUS_B);
  assign any_req = i_io_req.rd || i_io_req.wr;

  // Outputs reset de-asserted so contacts stay open until firmware writes
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ctrl_low <= RESET_OUTPUTS;
    end else if (wr_low) begin
      ctrl_low <= i_io_req.wdata; // [R3] [R15]
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ctrl_high <= CTRL_HIGH_PAD;
    end else if (wr_high) begin
      ctrl_high <= i_io_req.wdata[3:0]; // [R4] [R15]
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      internal_out <= RESET_OUTPUTS;
    end else if (wr_int) begin
      internal_out <= i_io_req.wdata;
    end
  end

  // Firmware encodes the flag meanings; the port just holds the byte
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      status_a <= RESET_OUTPUTS;
    end else if (wr_sta) begin
      status_a <= i_io_req.wdata; // [R6] [R7] [R8] [R9] [R10]
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      status_b <= RESET_OUTPUTS;
    end else if (wr_stb) begin
      status_b <= i_io_req.wdata; // [R11]
    end
  end

  // Pin n of the control connector follows bit n-1 of 0x321 for pins 1-8 and bit n-9 of 0x325 for pins 9-12
  genvar c;
  generate
    for (c = 0; c < 12; c++) begin : g_ctrl_pin
      if (c < 8) begin : g_low
        assign o_control_out_n[c] = ctrl_low[c]; // [R3]
      end else begin : g_high
        assign o_control_out_n[c] = ctrl_high[c-8]; // [R4]
      end
    end
  endgenerate

  assign o_internal_out  = internal_out;
  assign o_status_a      = status_a;
  assign o_status_b      = status_b;

  assign o_status_flags.health_flag_n        = status_a[BIT_HEALTH];   // [R6]
  assign o_status_flags.sequence_running_n   = status_a[BIT_SEQUENCE]; // [R7]
  assign o_status_flags.diagnostics_active_n = status_a[BIT_DIAG];     // [R8]
  assign o_status_flags.thermal_alarm_n      = status_a[BIT_THERMAL];  // [R9]
  assign o_status_flags.pressure_fault_n     = status_a[BIT_PRESSURE]; // [R10]

  // Upper two bits of each remote byte have no pin behind them
  assign remote_low_byte  = {INPUT_PAD, remote_sync[5:0]};  // [R1] [R15]
  assign remote_high_byte = {INPUT_PAD, remote_sync[11:6]}; // [R2] [R15]

  // Read mux; write-only addresses such as 0x323 read back zero
  always_comb begin
    next_rdata = 8'h00;
    case (i_io_req.addr)
      ADDR_CTRL_LOW: begin
        next_rdata = remote_low_byte; // [R1]
      end
      ADDR_CTRL_HIGH: begin
        next_rdata = remote_high_byte; // [R2]
      end
      ADDR_INTERNAL: begin
        next_rdata = internal_sync; // [R5]
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_io_rdata <= 8'h00;
    end else if (i_io_req.rd) begin
      o_io_rdata <= next_rdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_io_ack <= 1'b0;
    end else begin
      o_io_ack <= any_req;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      relay_reg <= RESET_RELAY;
    end else if (i_relay_wr) begin
      relay_reg <= i_relay_wdata; // [R13] [R15]
    end
  end

  assign keepalive_toggled = relay_reg[BIT_KEEPALIVE] != keepalive_last;
  assign window_expired    = stale_count >= 40'(WATCHDOG_LIMIT);

  // Keep-alive watchdog: any change of bit 0 restarts the window
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      keepalive_last <= 1'b1;
      stale_count <= 40'h0;
    end else if (keepalive_toggled) begin
      keepalive_last <= relay_reg[BIT_KEEPALIVE]; // [R12]
      stale_count <= 40'h0;
    end else if (!window_expired) begin
      stale_count <= stale_count + 40'h1; // Saturates so a long stall cannot wrap
    end
  end

  // Starts safe until firmware proves life; a toggle beats a lapse in the same cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      relay_state <= RELAY_SAFE;
    end else begin
      case (relay_state)
        RELAY_SAFE: begin
          if (keepalive_toggled) begin
            relay_state <= RELAY_LIVE;
          end
        end
        RELAY_LIVE: begin
          if (!keepalive_toggled && window_expired) begin
            relay_state <= RELAY_SAFE; // [R14]
          end
        end
        default: begin
          relay_state <= RELAY_SAFE;
        end
      endcase
    end
  end

  assign relay_active = (relay_state == RELAY_LIVE);

  // Safe state drives every line high, which turns the pump off
  genvar r;
  generate
    for (r = 0; r < 16; r++) begin : g_relay_line
      assign relay_masked[r] = relay_active ? relay_reg[r] : RESET_RELAY[r]; // [R13] [R14]
    end
  endgenerate

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_relay_out <= RESET_RELAY;
    end else begin
      o_relay_out <= relay_masked;
    end
  end

  assign o_relay_active = relay_active;
endmodule

// ==== dv/dio_ports_chk.sv ====
// Port assertions for the digital I/O port bank
`timescale 1ns/1ns
module dio_ports_chk #(
  parameter longint WATCHDOG_LIMIT = dio_pkg::WATCHDOG_CYCLES
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  input  wire dio_pkg::io_req_s i_io_req,
  input  wire logic [7:0]       o_io_rdata,
  input  wire logic             o_io_ack,
  input  wire logic [11:0]      o_control_out_n,
  input  wire logic [7:0]       o_status_a,
  input  wire logic             i_relay_wr,
  input  wire logic [15:0]      i_relay_wdata,
  input  wire logic [15:0]      o_relay_out,
  input  wire dio_pkg::status_s o_status_flags,
  input  wire logic             o_relay_active
);
  import dio_pkg::*;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  wire logic       rd = i_io_req.rd;
  wire logic       wr = i_io_req.wr;
  wire logic [9:0] a  = i_io_req.addr;
  logic            last_bit;
  longint          idle;
  // Restarts only on a real keep-alive toggle; saturates so a long stall cannot wrap
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      last_bit <= 1'b1;
      idle <= 0;
    end else if (i_relay_wr && i_relay_wdata[BIT_KEEPALIVE] != last_bit) begin
      last_bit <= i_relay_wdata[BIT_KEEPALIVE];
      idle <= 0;
    end else if (idle < WATCHDOG_LIMIT + 8) begin
      idle <= idle + 1;
    end
  end
  chk_ack_one: assert property (1 |=> o_io_ack == $past(rd | wr)) else $error("ack timing wrong");
  chk_rd_low: assert property (rd && a == ADDR_CTRL_LOW |=> o_io_rdata[7:6] == 2'b11) else $error("pad low");
  chk_rd_high: assert property (rd && a == ADDR_CTRL_HIGH |=> o_io_rdata[7:6] == 2'b11) else $error("pad hi");
  chk_wr_low: assert property (wr && a == ADDR_CTRL_LOW |=> o_control_out_n[7:0] == $past(i_io_req.wdata))
    else $error("ctrl low");
  chk_wr_high: assert property (
    wr && a == ADDR_CTRL_HIGH |=> o_control_out_n[11:8] == $past(i_io_req.wdata[3:0])) else $error("ctrl high");
  chk_out_hold: assert property (!wr |=> $stable(o_control_out_n) && $stable(o_status_a)) else $error("drift");
  chk_flag_copy: assert property (
    o_status_flags == {o_status_a[BIT_HEALTH], o_status_a[BIT_SEQUENCE], o_status_a[BIT_DIAG],
                       o_status_a[BIT_THERMAL], o_status_a[BIT_PRESSURE]}) else $error("flags");
  chk_relay_safe: assert property (!o_relay_active |=> o_relay_out == 16'hffff) else $error("relay live");
  chk_dog_bound: assert property (o_relay_active |-> idle <= WATCHDOG_LIMIT + 4) else $error("stale active");
  cover property (rd && a == ADDR_CTRL_HIGH);
  cover property ($rose(o_relay_active));
  cover property ($fell(o_relay_active));
endmodule
bind dio_ports dio_ports_chk #(.WATCHDOG_LIMIT(WATCHDOG_LIMIT)) dio_ports_chk_i (.*);

// ==== dv/dio_contacts.sv ====
// Contact closure model for the input pins
`timescale 1ns/1ns
module dio_contacts (
  input  wire logic [11:0] i_remote_set_n,
  input  wire logic [7:0]  i_internal_set,
  output logic      [11:0] o_remote_in_n,
  output logic      [7:0]  o_internal_in
);
  logic bounce = 1'b0;
  // Brief bounce between clock edges; pins follow the set levels from time zero
  always @(i_remote_set_n or i_internal_set) begin
    bounce = 1'b1;
    #2;
    bounce = 1'b0;
  end
  assign o_remote_in_n = bounce ? ~i_remote_set_n : i_remote_set_n;
  assign o_internal_in = bounce ? ~i_internal_set : i_internal_set;
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench for the digital I/O port bank
`timescale 1ns/1ns
module tb_top;
  import dio_pkg::*;
  localparam longint LIMIT = 20;
  logic        i_sys_clk, i_rst, i_relay_wr, o_io_ack, o_relay_active;
  io_req_s     i_io_req;
  logic [7:0]  o_io_rdata, i_internal_in, o_internal_out, o_status_a, o_status_b, int_set, d;
  logic [11:0] i_remote_in_n, o_control_out_n, rem_set;
  logic [15:0] i_relay_wdata, o_relay_out;
  status_s     o_status_flags;
  logic [7:0]  m [5];
  int          bad_count, total_checks, seed, k, n;
  dio_ports #(.WATCHDOG_LIMIT(LIMIT)) dio_ports_i (.*);
  dio_contacts dio_contacts_i (.i_remote_set_n(rem_set), .i_internal_set(int_set),
    .o_remote_in_n(i_remote_in_n), .o_internal_in(i_internal_in));
  initial begin
    i_sys_clk = 0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  task automatic cmp(string s, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic io(logic r, logic w, logic [9:0] a, logic [7:0] v);
    i_io_req = '{r, w, a, v};
    @(negedge i_sys_clk);
    cmp("ack", 16'h1, o_io_ack);
  endtask
  task automatic rd(logic [9:0] a, logic [7:0] e);
    io(1, 0, a, 8'h00);
    cmp("rdata", e, o_io_rdata);
  endtask
  task automatic relay(logic [15:0] v);
    i_relay_wr = 1;
    i_relay_wdata = v;
    @(negedge i_sys_clk);
    i_relay_wr = 0;
    repeat (3) @(negedge i_sys_clk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    seed = 82466;
    i_rst = 1;
    i_io_req = '0;
    i_relay_wr = 0;
    i_relay_wdata = '0;
    rem_set = '1;
    int_set = '0;
    repeat (4) @(negedge i_sys_clk);
    i_rst = 0;
    cmp("relay", 16'hffff, o_relay_out);
    for (k = 0; k < 5; k++) m[k] = 8'hff;
    repeat (16) begin
      i_io_req = '0;
      rem_set = 12'($random(seed));
      int_set = 8'($random(seed));
      repeat (8) @(negedge i_sys_clk);
      rd(ADDR_CTRL_LOW, {2'b11, rem_set[5:0]});
      rd(ADDR_CTRL_HIGH, {2'b11, rem_set[11:6]});
      rd(ADDR_INTERNAL, int_set);
      rd(ADDR_STATUS_B, 8'h00);
      // Unmapped writes land on k == 5 and must be ignored
      for (k = 0; k < 6; k++) begin
        d = 8'($random(seed));
        io(0, 1, 10'(ADDR_CTRL_LOW + k), d);
        if (k < 5) m[k] = d;
      end
      cmp("ctrl", {4'h0, m[4][3:0], m[0]}, o_control_out_n);
      cmp("int", m[1], o_internal_out);
      cmp("stat_a", m[2], o_status_a);
      cmp("flags", {m[2][0], m[2][2], m[2][3], m[2][4], m[2][5]}, o_status_flags);
      cmp("stat_b", m[3], o_status_b);
    end
    i_io_req = '0;
    for (n = 0; n < 6; n++) begin
      relay(16'hfffc | 16'(n & 1));
      cmp("relay", 16'hfffc | 16'(n & 1), o_relay_out);
      cmp("active", 16'h1, o_relay_active);
    end
    repeat (26) @(negedge i_sys_clk);
    cmp("active", 16'h0, o_relay_active);
    relay(16'hfffd);
    cmp("relay", 16'hffff, o_relay_out);
    i_rst = 1;
    repeat (2) @(negedge i_sys_clk);
    i_rst = 0;
    cmp("ctrl", 16'h0fff, o_control_out_n);
    cmp("stat_a", 16'h00ff, o_status_a);
    cmp("active", 16'h0, o_relay_active);
    tally_and_finish();
  end
endmodule
